// *** tb/sbfsm_lts_bench.sv ***
`timescale 1ns/1ns
`include "sbfsm_map.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
// self-checking bench for the line termination sequencer
module sbfsm_lts_bench
  import sbfsm_pkg::*;
();
  logic clk_i = 1'b0; // 125 mhz clock
  logic rstn_i = 1'b0; // reset, low active
  logic [3:0] cmd_i = `SBFSM_CMD_CLEAR; // controller command
  logic [1:0] mode = 2'h0; // terminal line signal
  logic viol_req = 1'b0; // violation injection
  logic ive = 1'b0; // violation report enable
  logic txoff = 1'b0; // transmit buffers off, low in reset to expose the reset value
  logic xoff = 1'b0; // transceiver off
  logic rx_info0, rx_info3, rx_sync, rx_viol; // receiver view
  logic [3:0] ind; // indication code
  sbfsm_tx_t txi; // transmitted info
  logic abit, den, drv, rxen, loopc; // frame and line controls
  int err_count = 0; // mismatches
  int samples_checked = 0; // comparisons
  // clock generator
  always #4 clk_i = ~clk_i;
  sbfsm_te_model te_u (.clk_i(clk_i), .rstn_i(rstn_i), .mode_i(mode), .viol_req_i(viol_req),
    .rx_info0_o(rx_info0), .rx_info3_o(rx_info3), .rx_sync_o(rx_sync), .rx_viol_o(rx_viol));
  sbfsm_lts #(.INFO0_CYC(23'h10), .GUARD_CYC(23'h20), .INTERIM_CYC(23'h8)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .cmd_i(cmd_i), .rx_info0_i(rx_info0), .rx_info3_i(rx_info3),
    .rx_sync_i(rx_sync), .rx_viol_i(rx_viol), .illegal_violation_enable_i(ive),
    .tx_buffer_off_bit_i(txoff), .xcvr_off_bit_i(xoff), .ind_o(ind), .tx_info_o(txi),
    .frame_a_bit_o(abit), .frame_data_en_o(den), .tx_drive_o(drv), .rx_enable_o(rxen),
    .loop_close_o(loopc));
  // settle point: n edges, then the falling edge
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : wait_n
  // command held until its action has started
  task automatic send(input logic [3:0] c, input int n);
    @(posedge clk_i);
    cmd_i <= c;
    wait_n(n);
  endtask : send
  // change what the terminal sends
  task automatic line(input logic [1:0] m, input int n);
    @(posedge clk_i);
    mode <= m;
    wait_n(n);
  endtask : line
  // one-cycle violation from the terminal
  task automatic pulse_viol;
    @(posedge clk_i);
    viol_req <= 1'b1;
    @(posedge clk_i);
    viol_req <= 1'b0;
    wait_n(3);
  endtask : pulse_viol
  // indication plus transmitted info
  task automatic look(input logic [3:0] ei, input sbfsm_tx_t et);
    `CHK("ind_o", ei, ind);
    `CHK("tx_info_o", et, txi);
  endtask : look
  // reset state, activation from the controller, buffer gating
  task automatic t_act;
    look(`SBFSM_IND_INTERIM, SBFSM_TX_INFO0);
    `CHK("tx_drive_o", 1'b0, drv);
    send(`SBFSM_CMD_CONFIRM, 3);
    look(`SBFSM_IND_DEACTIVATED, SBFSM_TX_INFO0);
    @(posedge clk_i);
    txoff <= 1'b0;
    send(`SBFSM_CMD_ACT, 3);
    look(`SBFSM_IND_NOT_SYNCED, SBFSM_TX_INFO2);
    `CHK("loop_close_o", 1'b0, loopc);
    line(2'h2, 4);
    `CHK("ind_o", `SBFSM_IND_ACT_REQ, ind);
    line(2'h3, 4); // bounded wait for info 3
    look(`SBFSM_IND_ACT_DONE, SBFSM_TX_INFO4);
    `CHK("frame_a_bit_o", 1'b1, abit);
    `CHK("frame_data_en_o", 1'b1, den);
    `CHK("tx_drive_o", 1'b1, drv);
    @(posedge clk_i);
    txoff <= 1'b1;
    wait_n(3);
    `CHK("tx_drive_o", 1'b0, drv);
    `CHK("rx_enable_o", 1'b1, rxen);
    @(posedge clk_i);
    txoff <= 1'b0;
  endtask : t_act
  // sync loss, recovery, violation reporting
  task automatic t_lost;
    line(2'h1, 4);
    look(`SBFSM_IND_NOT_SYNCED, SBFSM_TX_INFO2);
    `CHK("frame_a_bit_o", 1'b0, abit);
    `CHK("frame_data_en_o", 1'b0, den);
    line(2'h3, 4);
    look(`SBFSM_IND_ACT_DONE, SBFSM_TX_INFO4);
    pulse_viol();
    `CHK("ind_o", `SBFSM_IND_ACT_DONE, ind);
    @(posedge clk_i);
    ive <= 1'b1;
    pulse_viol();
    `CHK("ind_o", `SBFSM_IND_CODE_VIOL, ind);
    @(posedge clk_i);
    ive <= 1'b0;
    wait_n(3);
    `CHK("ind_o", `SBFSM_IND_ACT_DONE, ind);
  endtask : t_lost
  // deactivation ended by silence, wait state, loop activation
  task automatic t_short;
    send(`SBFSM_CMD_DEACT, 3);
    look(`SBFSM_IND_INTERIM, SBFSM_TX_INFO0);
    line(2'h0, 8);
    `CHK("ind_o", `SBFSM_IND_INTERIM, ind);
    wait_n(14);
    `CHK("ind_o", `SBFSM_IND_DEACTIVATED, ind);
    send(`SBFSM_CMD_ACT, 8);
    look(`SBFSM_IND_DEACTIVATED, SBFSM_TX_INFO0);
    send(`SBFSM_CMD_CONFIRM, 3);
    send(`SBFSM_CMD_ACT_LOOP, 3);
    look(`SBFSM_IND_NOT_SYNCED, SBFSM_TX_INFO2);
    `CHK("loop_close_o", 1'b1, loopc);
    line(2'h3, 4);
  endtask : t_short
  // deactivation ended by the guard timer, then activation from the line
  task automatic t_guard;
    line(2'h1, 4);
    send(`SBFSM_CMD_DEACT, 17);
    `CHK("ind_o", `SBFSM_IND_INTERIM, ind);
    // guard expires 32 cycles after entry, then one edge to state and one to indication
    wait_n(18);
    `CHK("ind_o", `SBFSM_IND_DEACTIVATED, ind);
    send(`SBFSM_CMD_CONFIRM, 2);
    look(`SBFSM_IND_INTERIM, SBFSM_TX_INFO0);
    wait_n(2);
    look(`SBFSM_IND_NOT_SYNCED, SBFSM_TX_INFO2);
  endtask : t_guard
  // test pulses, clear between them, line ignored under clear
  task automatic t_tests;
    send(`SBFSM_CMD_SINGLE, 3);
    look(`SBFSM_IND_INTERIM, SBFSM_TX_SINGLE);
    send(`SBFSM_CMD_CLEAR, 3); // no direct test to
    look(`SBFSM_IND_INTERIM, SBFSM_TX_INFO0);
    line(2'h3, 6);
    look(`SBFSM_IND_INTERIM, SBFSM_TX_INFO0);
    send(`SBFSM_CMD_CONT, 3);
    look(`SBFSM_IND_INTERIM, SBFSM_TX_CONT);
    send(`SBFSM_CMD_CLEAR, 3);
  endtask : t_tests
  // transceiver off stops everything and resets the sequencer
  task automatic t_off;
    send(`SBFSM_CMD_CONFIRM, 6);
    look(`SBFSM_IND_ACT_DONE, SBFSM_TX_INFO4);
    // confirm stays applied, so only the off bit can pull the sequencer back
    @(posedge clk_i);
    xoff <= 1'b1;
    wait_n(3);
    `CHK("rx_enable_o", 1'b0, rxen);
    `CHK("tx_drive_o", 1'b0, drv);
    look(`SBFSM_IND_INTERIM, SBFSM_TX_INFO0);
    // clear before release so the line cannot restart activation
    send(`SBFSM_CMD_CLEAR, 1);
    @(posedge clk_i);
    xoff <= 1'b0;
    wait_n(3);
    look(`SBFSM_IND_INTERIM, SBFSM_TX_INFO0);
    `CHK("rx_enable_o", 1'b1, rxen);
    `CHK("tx_drive_o", 1'b1, drv);
  endtask : t_off
  // counts, verdict, end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    @(posedge clk_i);
    @(negedge clk_i);
    // input low yet buffers off: only the reset value of the bit does that
    `CHK("tx_drive_o", 1'b0, drv);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    txoff <= 1'b1;
    wait_n(1);
    t_act();
    t_lost();
    t_short();
    t_guard();
    t_tests();
    t_off();
    give_verdict();
  end
  // hang guard, about thirteen times the expected run
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end
endmodule : sbfsm_lts_bench

// *** tb/sbfsm_te_model.sv ***
`timescale 1ns/1ns
// terminal equipment on the far side of the s/t line, seen through the receiver
module sbfsm_te_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] mode_i, // 0 silence, 1 wake pattern, 2 framed, 3 info 3
  input wire logic viol_req_i, // inject one code violation
  output logic rx_info0_o, // line silent
  output logic rx_info3_o, // info 3 heard
  output logic rx_sync_o, // frames aligned
  output logic rx_viol_o // one-cycle violation pulse
);
  logic next_info0; // next silent flag
  logic next_info3; // next info 3 flag
  logic next_sync; // next alignment flag
  logic next_viol; // next violation pulse
  // decode of the signal the terminal puts on the line
  always_comb begin
    next_info0 = (mode_i == 2'h0); // nothing sent
    next_info3 = (mode_i == 2'h3); // framed operational data
    next_sync = mode_i[1]; // wake pattern is unframed
    next_viol = viol_req_i & mode_i[1]; // violations only inside frames
  end
  // receiver view, registered once like a real front end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_info0_o <= 1'b1;
      rx_info3_o <= 1'b0;
      rx_sync_o <= 1'b0;
      rx_viol_o <= 1'b0;
    end else begin
      rx_info0_o <= next_info0;
      rx_info3_o <= next_info3;
      rx_sync_o <= next_sync;
      rx_viol_o <= next_viol;
    end
  end
endmodule : sbfsm_te_model

// *** verilog/sbfsm_lts.sv ***
`timescale 1ns/1ns
`include "sbfsm_map.svh"
// Summary of operation
// - activated state sends INFO 4 until left
// - sync loss goes lost-framing, sends INFO 2
// - INFO 3 again resumes INFO 4
// - deactivation pending, done on 16/32 ms
// - wait state held until confirm command
// - single-pulse test sends single pulses
// - continuous-pulse test sends continuous pulses
// - code 0000 starts full deactivation
// - code 0001 resets, line infos ignored
// - code 1000 starts activation
// - code 1010 activates with analog loop
// - code 1111 enters deactivated, detection on
// - interim indication 0000 in deactivated state while a signal is heard, up to 8 ms
// - indication 0100 while receiver not synchronous
// - indication 1000 on non-INFO 0 activation
// - indication 1011 on violation when enabled
// - indication 1100 when synced and active
// - transmit-off bit gates buffers, resets one
// - transceiver-off bit stops all functions
// - INFO 2 frames with zero data, A zero
// - deactivated plus stimulus sends INFO 2
module sbfsm_lts
  import sbfsm_pkg::*;
#(
  parameter logic [22:0] INFO0_CYC = 23'(`SBFSM_INFO0_CYC),
  parameter logic [22:0] GUARD_CYC = 23'(`SBFSM_GUARD_CYC),
  parameter logic [22:0] INTERIM_CYC = 23'(`SBFSM_INTERIM_CYC)
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] cmd_i, // command code from controller
  input wire logic rx_info0_i, // receiver sees INFO 0
  input wire logic rx_info3_i, // receiver sees INFO 3
  input wire logic rx_sync_i, // receiver frame synchronous
  input wire logic rx_viol_i, // illegal code violation pulse
  input wire logic illegal_violation_enable_i, // report violations
  input wire logic tx_buffer_off_bit_i, // transmit buffers off
  input wire logic xcvr_off_bit_i, // whole transceiver off
  output logic [3:0] ind_o, // indication code to controller
  output sbfsm_tx_t tx_info_o, // info to transmit
  output logic frame_a_bit_o, // A bit in sent frames
  output logic frame_data_en_o, // B, D, echo carry data
  output logic tx_drive_o, // transmit buffers enabled
  output logic rx_enable_o, // receiver and level detect on
  output logic loop_close_o // analog loop near the line
);
  sbfsm_state_t state; // current layer-1 state
  sbfsm_state_t next_state;
  logic loop; // loop requested at activation
  logic next_loop;
  logic txoff; // transmit-off bit, resets to one
  logic next_txoff;
  logic viol; // sticky violation while active
  logic next_viol;
  logic [3:0] next_ind;
  sbfsm_tx_t next_tx;
  logic t_short, t_long, i_long;
  logic info0_ok; // INFO 0 held 16 ms
  logic armed; // deactivated state entered via confirm
  logic next_armed;

  // line infos only matter when not being cleared and not powered off
  function automatic logic live(input logic [3:0] c, input logic off);
    return (c != `SBFSM_CMD_CLEAR) && !off;
  endfunction : live

  // deactivation timers: 16 ms of INFO 0 and 32 ms guard
  sbfsm_timer #(.SHORT_CYC(INFO0_CYC), .LONG_CYC(GUARD_CYC)) u_deact_timer (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .restart_i(state != SBFSM_PEND_DEACT),
    .run_i(1'b1),
    .short_o(),
    .long_o(t_long)
  );
  // INFO 0 run timer, restarts whenever INFO 0 is absent
  sbfsm_timer #(.SHORT_CYC(INFO0_CYC), .LONG_CYC(INFO0_CYC)) u_info0_timer (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .restart_i(state != SBFSM_PEND_DEACT || !rx_info0_i),
    .run_i(1'b1),
    .short_o(t_short),
    .long_o()
  );
  // interim indication timer in the deactivated state
  sbfsm_timer #(.SHORT_CYC(INTERIM_CYC), .LONG_CYC(INTERIM_CYC)) u_interim_timer (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .restart_i(state != SBFSM_DEACT || rx_info0_i),
    .run_i(1'b1),
    .short_o(),
    .long_o(i_long)
  );
  assign info0_ok = t_short;

  // next state of the layer-1 sequencer
  always_comb begin
    next_state = state;
    next_loop = loop;
    next_armed = armed;
    if (xcvr_off_bit_i) begin
      next_state = SBFSM_RESET; // all functions stop
      next_loop = 1'b0;
    end else if (cmd_i == `SBFSM_CMD_CLEAR) begin
      next_state = SBFSM_RESET; // unconditional clear
      next_loop = 1'b0;
      next_armed = 1'b0;
    end else if (cmd_i == `SBFSM_CMD_SINGLE) begin
      next_state = SBFSM_TEST_SINGLE;
    end else if (cmd_i == `SBFSM_CMD_CONT) begin
      next_state = SBFSM_TEST_CONT;
    end else begin
      case (state)
        SBFSM_RESET, SBFSM_TEST_SINGLE, SBFSM_TEST_CONT: begin
          if (cmd_i == `SBFSM_CMD_CONFIRM) begin
            next_state = SBFSM_DEACT;
            next_armed = 1'b1;
          end else if (cmd_i == `SBFSM_CMD_ACT || cmd_i == `SBFSM_CMD_ACT_LOOP) begin
            next_state = SBFSM_PEND_ACT;
            next_loop = (cmd_i == `SBFSM_CMD_ACT_LOOP);
          end
        end
        SBFSM_DEACT: begin
          // stimulus from line or controller
          if (cmd_i == `SBFSM_CMD_ACT || cmd_i == `SBFSM_CMD_ACT_LOOP) begin
            next_state = SBFSM_PEND_ACT;
            next_loop = (cmd_i == `SBFSM_CMD_ACT_LOOP);
          end else if (!rx_info0_i && armed) begin
            next_state = SBFSM_PEND_ACT;
            next_loop = 1'b0;
          end
        end
        SBFSM_PEND_ACT: begin
          if (cmd_i == `SBFSM_CMD_DEACT) begin
            next_state = SBFSM_PEND_DEACT;
          end else if (rx_info3_i && rx_sync_i) begin
            next_state = SBFSM_ACTIVE;
          end
        end
        SBFSM_ACTIVE: begin
          if (cmd_i == `SBFSM_CMD_DEACT) begin
            next_state = SBFSM_PEND_DEACT;
          end else if (!rx_sync_i) begin
            next_state = SBFSM_LOST_FRAME;
          end
        end
        SBFSM_LOST_FRAME: begin
          if (cmd_i == `SBFSM_CMD_DEACT) begin
            next_state = SBFSM_PEND_DEACT;
          end else if (rx_info3_i && rx_sync_i) begin
            next_state = SBFSM_ACTIVE;
          end
        end
        SBFSM_PEND_DEACT: begin
          next_loop = 1'b0;
          if (info0_ok || t_long) begin
            next_state = SBFSM_WAIT_CONFIRM;
          end
        end
        SBFSM_WAIT_CONFIRM: begin
          if (cmd_i == `SBFSM_CMD_CONFIRM) begin
            next_state = SBFSM_DEACT;
            next_armed = 1'b1;
          end
        end
        default: begin
          next_state = SBFSM_RESET;
        end
      endcase
    end
  end

  // register the sequencer state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= SBFSM_RESET;
      loop <= 1'b0;
      armed <= 1'b0;
    end else begin
      state <= next_state;
      loop <= next_loop;
      armed <= next_armed;
    end
  end

  // next transmit-off bit and sticky violation flag
  always_comb begin
    next_txoff = tx_buffer_off_bit_i;
    next_viol = viol;
    if (state != SBFSM_ACTIVE || !illegal_violation_enable_i) begin
      next_viol = 1'b0;
    end else if (rx_viol_i && live(cmd_i, xcvr_off_bit_i)) begin
      next_viol = 1'b1;
    end
  end

  // register transmit-off, reset value is off
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      txoff <= `SBFSM_TXOFF_RST;
      viol <= 1'b0;
    end else begin
      txoff <= next_txoff;
      viol <= next_viol;
    end
  end

  // indication and transmit info from state
  always_comb begin
    next_ind = `SBFSM_IND_INTERIM;
    next_tx = SBFSM_TX_INFO0;
    case (state)
      SBFSM_RESET: begin
        next_ind = `SBFSM_IND_INTERIM;
      end
      SBFSM_DEACT: begin
        // interim while a signal is heard, until 8 ms
        next_ind = (!rx_info0_i && !i_long) ? `SBFSM_IND_INTERIM : `SBFSM_IND_DEACTIVATED;
      end
      SBFSM_PEND_ACT: begin
        next_tx = SBFSM_TX_INFO2;
        next_ind = rx_sync_i ? `SBFSM_IND_ACT_REQ : `SBFSM_IND_NOT_SYNCED;
      end
      SBFSM_ACTIVE: begin
        next_tx = SBFSM_TX_INFO4;
        if (viol) begin
          next_ind = `SBFSM_IND_CODE_VIOL;
        end else begin
          next_ind = `SBFSM_IND_ACT_DONE;
        end
      end
      SBFSM_LOST_FRAME: begin
        next_tx = SBFSM_TX_INFO2;
        next_ind = `SBFSM_IND_NOT_SYNCED;
      end
      SBFSM_PEND_DEACT: begin
        next_ind = `SBFSM_IND_INTERIM;
      end
      SBFSM_WAIT_CONFIRM: begin
        next_ind = `SBFSM_IND_DEACTIVATED;
      end
      SBFSM_TEST_SINGLE: begin
        next_tx = SBFSM_TX_SINGLE;
      end
      SBFSM_TEST_CONT: begin
        next_tx = SBFSM_TX_CONT;
      end
      default: begin
        next_tx = SBFSM_TX_INFO0;
      end
    endcase
  end

  // register the outputs
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ind_o <= `SBFSM_IND_INTERIM;
      tx_info_o <= SBFSM_TX_INFO0;
    end else begin
      ind_o <= next_ind;
      tx_info_o <= next_tx;
    end
  end

  // frame content follows the sent info
  assign frame_a_bit_o = (tx_info_o == SBFSM_TX_INFO4);
  assign frame_data_en_o = (tx_info_o == SBFSM_TX_INFO4);
  assign tx_drive_o = !txoff && !xcvr_off_bit_i;
  assign rx_enable_o = !xcvr_off_bit_i;
  assign loop_close_o = loop && !xcvr_off_bit_i;

  // checks
  a_active_info4: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == SBFSM_ACTIVE |=> tx_info_o == SBFSM_TX_INFO4) else $error("active not sending info 4");
  a_lost_frame: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == SBFSM_ACTIVE && !rx_sync_i && cmd_i == `SBFSM_CMD_ACT && !xcvr_off_bit_i
    |=> state == SBFSM_LOST_FRAME ##1 tx_info_o == SBFSM_TX_INFO2) else $error("sync loss not handled");
  a_resume_info4: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == SBFSM_LOST_FRAME && rx_info3_i && rx_sync_i && cmd_i == `SBFSM_CMD_ACT && !xcvr_off_bit_i
    |=> state == SBFSM_ACTIVE) else $error("no resume on info 3");
  a_deact_done: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == SBFSM_WAIT_CONFIRM |=> ind_o == `SBFSM_IND_DEACTIVATED) else $error("wait state ind wrong");
  a_wait_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == SBFSM_WAIT_CONFIRM && !xcvr_off_bit_i && cmd_i == `SBFSM_CMD_DEACT
    |=> state == SBFSM_WAIT_CONFIRM) else $error("wait state left early");
  a_clear_cmd: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cmd_i == `SBFSM_CMD_CLEAR |=> state == SBFSM_RESET) else $error("clear not taken");
  a_test_cont: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cmd_i == `SBFSM_CMD_CONT && !xcvr_off_bit_i |=> ##1 tx_info_o == SBFSM_TX_CONT) else $error("no cont pulses");
  a_xcvr_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    xcvr_off_bit_i |-> !tx_drive_o && !rx_enable_o) else $error("transceiver not off");
  c_activation: cover property (@(posedge clk_i) disable iff (!rstn_i)
    state == SBFSM_PEND_ACT ##1 state == SBFSM_ACTIVE);
  c_lost_frame: cover property (@(posedge clk_i) disable iff (!rstn_i)
    state == SBFSM_LOST_FRAME ##1 state == SBFSM_ACTIVE);
  c_deact: cover property (@(posedge clk_i) disable iff (!rstn_i)
    state == SBFSM_PEND_DEACT ##1 state == SBFSM_WAIT_CONFIRM);
endmodule : sbfsm_lts

// *** verilog/sbfsm_map.svh ***
`ifndef SBFSM_MAP_SVH
`define SBFSM_MAP_SVH
// command codes on the command channel
`define SBFSM_CMD_DEACT 4'h0
`define SBFSM_CMD_CLEAR 4'h1
`define SBFSM_CMD_SINGLE 4'h2
`define SBFSM_CMD_CONT 4'h3
`define SBFSM_CMD_ACT 4'h8
`define SBFSM_CMD_ACT_LOOP 4'hA
`define SBFSM_CMD_CONFIRM 4'hF
// indication codes
`define SBFSM_IND_INTERIM 4'h0
`define SBFSM_IND_NOT_SYNCED 4'h4
`define SBFSM_IND_ACT_REQ 4'h8
`define SBFSM_IND_CODE_VIOL 4'hB
`define SBFSM_IND_ACT_DONE 4'hC
`define SBFSM_IND_DEACTIVATED 4'hF
// timing figures
`define SBFSM_CLK_MHZ 125
`define SBFSM_INFO0_MS 16
`define SBFSM_GUARD_MS 32
`define SBFSM_INTERIM_MS 8
`define SBFSM_CYC_PER_MS (`SBFSM_CLK_MHZ * 1000)
`define SBFSM_INFO0_CYC (`SBFSM_INFO0_MS * `SBFSM_CYC_PER_MS)
`define SBFSM_GUARD_CYC (`SBFSM_GUARD_MS * `SBFSM_CYC_PER_MS)
`define SBFSM_INTERIM_CYC (`SBFSM_INTERIM_MS * `SBFSM_CYC_PER_MS)
// reset value of the transmit-off disable bit
`define SBFSM_TXOFF_RST 1'b1
`endif

// *** verilog/sbfsm_pkg.sv ***
package sbfsm_pkg;
  // layer-1 states of the line termination side
  typedef enum logic [3:0] {
    SBFSM_RESET,
    SBFSM_DEACT,
    SBFSM_PEND_ACT,
    SBFSM_ACTIVE,
    SBFSM_LOST_FRAME,
    SBFSM_PEND_DEACT,
    SBFSM_WAIT_CONFIRM,
    SBFSM_TEST_SINGLE,
    SBFSM_TEST_CONT
  } sbfsm_state_t;
  // transmitted line info
  typedef enum logic [2:0] {
    SBFSM_TX_INFO0,
    SBFSM_TX_INFO2,
    SBFSM_TX_INFO4,
    SBFSM_TX_SINGLE,
    SBFSM_TX_CONT
  } sbfsm_tx_t;
endpackage : sbfsm_pkg

// *** verilog/sbfsm_timer.sv ***
`timescale 1ns/1ns
`include "sbfsm_map.svh"
// interval counter with restart and two threshold flags
module sbfsm_timer #(
  parameter int W = 23,
  parameter logic [22:0] SHORT_CYC = 23'(`SBFSM_INFO0_CYC),
  parameter logic [22:0] LONG_CYC = 23'(`SBFSM_GUARD_CYC)
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic restart_i,
  input wire logic run_i,
  output logic short_o,
  output logic long_o
);
  logic [W-1:0] count; // elapsed cycles
  logic [W-1:0] next_count;
  // next count: restart clears, run advances, saturates at long limit
  always_comb begin
    next_count = count;
    if (restart_i) begin
      next_count = '0;
    end else if (run_i && count < W'(LONG_CYC)) begin
      next_count = count + W'(1);
    end
  end
  // register the count
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
  assign short_o = count >= W'(SHORT_CYC);
  assign long_o = count >= W'(LONG_CYC);
endmodule : sbfsm_timer
